// ===== core/eeprom_write_core.sv
// serial eeprom word write and write-all path with ready/busy report
//
// Notes on behaviour
// R1: after write command and address, sixteen data bits are stored at that address
// R2: last data bit of a word write starts self-timed erase then program
// R3: select low 250 ns then high shows ready/busy until the cycle ends
// R4: while programming runs, the status output is driven low
// R5: when a word write finishes, the status output goes high
// R6: write-all programs every location with the one supplied word
// R7: write-all cycle starts on the edge shifting in the last data bit
// R8: write-all completes without any further serial clock edges
// R9: write-all erases the whole array itself before programming
// R10: write-all is done only while programming is enabled
// R11: during write-all, status shows after select low 250 ns then high
// R12: a command starts at the first rising clock with select and data high
// R13: power-up leaves programming disabled; writes before enable are refused
// R14: the serial output floats on the falling edge of select
// R15: bits are sampled on rising edges of the serial clock
// R16: frame is start, two opcode bits, six address bits, sixteen data bits
// R17: a frame cut short by select falling starts no programming
`include "eeprom_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_core #(
  parameter int ERASE_CYCLES = `ERASE_CYC,
  parameter int PROG_CYCLES  = `PROG_CYC,
  parameter int FIFO_DEPTH   = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic chipSelect,
  input  wire logic serialClk,
  input  wire logic serial_in,
  output logic      serialOut,
  output logic      serialOutEn_n,
  output logic      busy
);
  import eeprom_pkg::*;

  // ==========================================================
  // pin synchronisers
  // all three pins pass two flops before any logic reads them
  wire [2:0] pinsSync;
  wire       csS;
  wire       sclkS;
  wire       sdiS;

  pin_sync #(.WIDTH(3)) uPins (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({chipSelect, serialClk, serial_in}),
    .pinOut  (pinsSync)
  );
  assign {csS, sclkS, sdiS} = pinsSync;

  // edge detection on synchronised pins
  // delay flops reset to the idle-low pin level, so no false edge follows reset
  logic csDly;
  logic sclkDly;
  wire  sclkRise;
  wire  csRise;
  wire  csFall;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csDly   <= 1'b0;
      sclkDly <= 1'b0;
    end
    else
    begin
      csDly   <= csS;
      sclkDly <= sclkS;
    end
  end
  assign sclkRise = sclkS && !sclkDly && csS; // see R15
  assign csRise   = csS && !csDly;
  assign csFall   = !csS && csDly;

  // ==========================================================
  // frame shifter
  logic        started;
  logic [4:0]  bitCount;
  logic [23:0] shiftReg;
  wire  [23:0] next_shift;
  wire  [4:0]  next_count;
  wire         startBit;
  wire         frameBit;
  assign startBit   = sclkRise && !started && sdiS; // see R12
  assign frameBit   = sclkRise && started && (bitCount != 5'(`FRAME_BITS));
  assign next_shift = {shiftReg[22:0], sdiS}; // msb first, see R16
  assign next_count = bitCount + 5'h1;

  // command decode on completed field boundaries
  wire [1:0] opField   = next_shift[7:6];
  wire [1:0] subField  = next_shift[5:4];
  wire       cmdDone   = frameBit && (next_count == 5'(`CMD_BITS));
  wire       dataDone  = frameBit && (next_count == 5'(`FRAME_BITS));
  wire       isEnable  = cmdDone && opField == `OP_PROG && subField == `SUB_ENABLE;
  wire       isDisable = cmdDone && opField == `OP_PROG && subField == `SUB_DISABLE;
  // the last data bit is still entering when the frame completes, so the
  // frame fields are taken from the shifted value, not the stored one
  wire [1:0] frOp      = next_shift[23:22];
  wire [1:0] frSub     = next_shift[21:20];
  wire       isWrite   = frOp == `OP_WRITE;
  wire       isAll     = frOp == `OP_PROG && frSub == `SUB_WRITE_ALL;

  // start detection, bit count and shifting; select low aborts the frame
  // the shift register is not cleared between frames; fields are read whole at the last bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      started  <= 1'b0;
      bitCount <= 5'h0;
      shiftReg <= 24'h0;
    end
    else if (!csS)
    begin
      started  <= 1'b0; // see R17
      bitCount <= 5'h0;
    end
    else if (startBit)
    begin
      started  <= 1'b1;
      bitCount <= 5'h1;
    end
    else if (frameBit)
    begin
      shiftReg <= next_shift;
      bitCount <= next_count;
    end
  end

  // ==========================================================
  // programming enable latch, disabled out of reset
  // a cut enable or disable frame never reaches its ninth bit and changes nothing
  logic progEnable;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      progEnable <= 1'b0; // see R13
    else if (isEnable)
      progEnable <= 1'b1;
    else if (isDisable)
      progEnable <= 1'b0;
  end

  // ==========================================================
  // request fifo between the shifter and the programmer
  // a frame that completes while the queue is full is dropped; poll before sending more
  wr_req_s reqIn;
  wr_req_s reqOut;
  wire     reqValid;
  wire     reqReady;
  wire     reqInReady;
  wire     reqPush;
  assign reqIn.all  = isAll;
  assign reqIn.addr = next_shift[21:16];
  assign reqIn.data = next_shift[15:0]; // see R1
  // only complete, enabled frames reach the programmer
  assign reqPush = dataDone && progEnable && (isWrite || isAll); // see R2 R7 R10 R13 R17

  sync_fifo #(.WIDTH($bits(wr_req_s)), .DEPTH(FIFO_DEPTH)) uReqFifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inData   (reqIn),
    .inValid  (reqPush),
    .inReady  (reqInReady),
    .outData  (reqOut),
    .outValid (reqValid),
    .outReady (reqReady)
  );

  // ==========================================================
  // self-timed programmer: one job at a time, erase then program
  // a write-all sweeps the erase over every word before programming any of them
  // the serial clock may stop once a job is queued; nothing here waits on it
  logic [15:0] mem [`WORDS];
  prog_state_e state;
  prog_state_e next_state;
  logic [15:0] timer;
  wr_req_s     cur;
  logic [5:0]  sweep;
  wire         timerDone = (timer == 16'h0);
  wire         sweepLast = !cur.all || (sweep == 6'(`WORDS - 1));
  wire         pendBusy  = reqPush || reqValid || !reqInReady;
  assign reqReady = (state == IDLE);

  // next state; no serial clock needed once running
  always_comb
  begin
    next_state = state;
    case (state)
      IDLE:  if (reqValid) next_state = ERASE;
      ERASE: if (timerDone && sweepLast) next_state = PROG; // see R8 R9
      PROG:  if (timerDone && sweepLast) next_state = DONE;
      DONE:  next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  // state, timer and sweep index
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IDLE;
      timer <= 16'h0;
      sweep <= 6'h0;
      cur   <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == IDLE && reqValid)
      begin
        cur   <= reqOut;
        sweep <= 6'h0;
        timer <= 16'(ERASE_CYCLES - 1);
      end
      else if (state == ERASE || state == PROG)
      begin
        if (!timerDone)
          timer <= timer - 16'h1;
        else if (!sweepLast)
        begin
          sweep <= sweep + 6'h1;
          timer <= 16'(((state == ERASE) ? ERASE_CYCLES : PROG_CYCLES) - 1);
        end
        else
        begin
          sweep <= 6'h0;
          timer <= 16'(PROG_CYCLES - 1);
        end
      end
    end
  end

  // array update: erase to ones, then program the word
  // the array has no reset; a word is unknown until it is first written
  wire [5:0] memIdx    = cur.all ? sweep : cur.addr;
  wire       eraseStep = (state == ERASE) && timerDone;
  wire       progStep  = (state == PROG) && timerDone;
  always_ff @(posedge clk_sys)
  begin
    if (eraseStep)
      mem[memIdx] <= `ERASED_WORD; // see R9
    else if (progStep)
      mem[memIdx] <= cur.data; // see R1 R6
  end

  // ==========================================================
  // ready/busy reporting on the serial output
  // status opens only if work is pending as select rises; once done it shows ready
  logic [4:0] lowCount;
  logic       lowMet;
  logic       showStatus;
  wire        progBusy  = (state != IDLE) || pendBusy;
  wire        lowFull   = (lowCount == 5'(`SELECT_LOW_CYC));
  wire        pollStart = csRise && lowMet && progBusy; // see R3 R11

  // select-low timer; saturates so a long idle low cannot wrap
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowCount <= 5'h0;
      lowMet   <= 1'b0;
    end
    else
    begin
      if (csS)
        lowCount <= 5'h0;
      else if (!lowFull)
        lowCount <= lowCount + 5'h1;
      lowMet <= !csS && lowFull; // see R3 R11
    end
  end

  // status window: opened by a poll, closed by select falling or a new command
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      showStatus <= 1'b0;
    else if (csFall)
      showStatus <= 1'b0; // see R14
    else if (pollStart)
      showStatus <= 1'b1;
    else if (startBit)
      showStatus <= 1'b0;
  end

  // registered pin outputs; the enable is active low
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serialOut     <= 1'b0;
      serialOutEn_n <= 1'b1;
      busy          <= 1'b0;
    end
    else
    begin
      busy          <= progBusy;
      serialOut     <= !progBusy; // see R4 R5
      serialOutEn_n <= !(showStatus && csS);
    end
  end
endmodule : eeprom_write_core
`default_nettype wire

// ===== core/pin_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0]      pinOut
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      pinOut <= '0;
    end
    else
    begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== core/sync_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doPush;
  wire              doPop;

  // handshakes and flags
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // storage array
  always_ff @(posedge clk_sys)
  begin
    if (doPush)
      mem[wrPtr] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (doPop)
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end
endmodule : sync_fifo
`default_nettype wire

// ===== dv/eeprom_write_monitor.sv
// port checker for the serial eeprom write path
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_monitor #(
  parameter int ERASE_CYCLES = 64,
  parameter int PROG_CYCLES  = 64
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chipSelect,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  input wire logic busy
);
  localparam int BUSY_MAX = 5 * 64 * (ERASE_CYCLES + PROG_CYCLES);
  int lowRun;
  int lowHeld;
  int busyRun;
  // ==========
  // run lengths of select low and of busy
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowRun  <= 0;
      lowHeld <= 0;
      busyRun <= 0;
    end
    else
    begin
      lowRun  <= chipSelect ? 0 : lowRun + 1;
      lowHeld <= (chipSelect && lowRun != 0) ? lowRun : lowHeld;
      busyRun <= busy ? busyRun + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  float_off_a: assert property ((!chipSelect) [*5] |-> serialOutEn_n)
    else $error("status driven while deselected");
  low_time_a: assert property ($fell(serialOutEn_n) |-> lowHeld >= 25)
    else $error("status after short select low");
  status_busy_a: assert property ($fell(serialOutEn_n) |-> chipSelect && $past(chipSelect, 2) && $past(busy))
    else $error("status without select or work");
  busy_low_a: assert property ((busy && !serialOutEn_n) [*2] |-> !$past(serialOut))
    else $error("ready shown while busy");
  done_ready_a: assert property ($fell(busy) && !serialOutEn_n |-> ##[0:2] serialOut)
    else $error("ready missing at completion");
  idle_ready_a: assert property ((!serialOutEn_n && !busy) [*3] |-> serialOut)
    else $error("ready dropped when idle");
  rise_frame_a: assert property ($rose(busy) |-> chipSelect && $past(chipSelect, 4))
    else $error("work started outside a frame");
  busy_bound_a: assert property (busyRun <= BUSY_MAX)
    else $error("programming never ends");
endmodule : eeprom_write_monitor

bind eeprom_write_core eeprom_write_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon_u (
  .clk_sys, .rst_n, .chipSelect, .serialOut, .serialOutEn_n, .busy);
`default_nettype wire

// ===== dv/serial_master.sv
// master model driving select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module serial_master #(
  parameter int HALF = 8
) (
  input  wire logic clk_sys,
  output var logic  chipSelect,
  output var logic  serialClk,
  output var logic  serial_in
);
  initial
  begin
    chipSelect = 1'b0;
    serialClk  = 1'b0;
    serial_in  = 1'b0;
  end
  // ==========
  // frame msb first down to bit cut, clock still outside frames
  task automatic send(input logic [24:0] f, input int n, input int cut);
    int i;
    @(posedge clk_sys);
    chipSelect <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
    chipSelect <= 1'b1;
    repeat (HALF) @(posedge clk_sys);
    for (i = n - 1; i >= cut; i--)
    begin
      serial_in <= f[i];
      repeat (HALF) @(posedge clk_sys);
      serialClk <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      serialClk <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    chipSelect <= 1'b0;
    serial_in  <= ~f[cut]; // released line shows the inverse
  endtask : send
  // select low for a while then high to ask for status
  task automatic poll(input int lowCyc);
    @(posedge clk_sys);
    chipSelect <= 1'b0;
    repeat (lowCyc) @(posedge clk_sys);
    chipSelect <= 1'b1;
  endtask : poll
endmodule : serial_master
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the serial eeprom write path
`include "eeprom_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int STEP = 32;
  localparam int WORD = 2 * STEP;
  localparam int JOB  = 2; // start and completion cycles around each job
  logic clk_sys = 1'b0;
  logic rst_n   = 1'b0;
  wire logic chipSelect, serialClk, serial_in, serialOut, serialOutEn_n, busy;
  int n_errors    = 0;
  int check_count = 0;
  int busyTotal   = 0;
  // ==========
  // clock and busy cycle tally
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) busyTotal <= busyTotal + int'(busy === 1'b1);
  eeprom_write_core #(.ERASE_CYCLES(STEP), .PROG_CYCLES(STEP), .FIFO_DEPTH(4)) dut_u (
    .clk_sys, .rst_n, .chipSelect, .serialClk, .serial_in, .serialOut, .serialOutEn_n, .busy);
  serial_master master_u (.clk_sys, .chipSelect, .serialClk, .serial_in);
  // frame builders
  function automatic logic [24:0] word_frame(input logic [5:0] a, input logic [15:0] d);
    return {1'b1, `OP_WRITE, a, d};
  endfunction : word_frame
  function automatic logic [24:0] all_frame(input logic [15:0] d);
    return {1'b1, `OP_PROG, `SUB_WRITE_ALL, 4'h0, d};
  endfunction : all_frame
  function automatic logic [24:0] ctl_frame(input logic [1:0] s);
    return {16'h0, 1'b1, `OP_PROG, s, 4'h0};
  endfunction : ctl_frame
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %0h expected %0h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_len(input int got, input int exp);
    check_count++;
    if (got < exp || got > exp + 8)
    begin
      n_errors++;
      $display("wrong value at %0t: %0h expected %0h", $time, got, exp);
    end
  endtask : check_len
  task automatic idle();
    int i;
    repeat (10) @(posedge clk_sys);
    for (i = 0; i < 9000 && busy !== 1'b0; i++)
      @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : idle
  task automatic run(input logic [24:0] f, input int n, input int cut, input int exp);
    int start;
    start = busyTotal;
    master_u.send(f, n, cut);
    idle();
    check_len(busyTotal - start, exp);
  endtask : run
  // poll and look at the status, optionally until completion
  task automatic status(input int lowCyc, input logic shown, input logic finish);
    master_u.poll(lowCyc);
    repeat (6) @(posedge clk_sys);
    check_bit(serialOutEn_n, !shown);
    if (shown)
      check_bit(serialOut, 1'b0);
    if (finish)
    begin
      idle();
      check_bit(serialOut, 1'b1);
    end
  endtask : status
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end
  // ==========
  // main sequence
  initial
  begin
    int i;
    int start;
    void'($urandom(17675));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    run(word_frame(6'h3f, 16'h1234), 25, 0, 0);
    run(all_frame(16'h0), 25, 0, 0);
    run(ctl_frame(`SUB_ENABLE), 9, 0, 0);
    $display("test lock done");
    for (i = 0; i < 6; i++)
      run(word_frame(i < 2 ? {6{i[0]}} : 6'($urandom), 16'($urandom)), 25, 0, WORD + JOB);
    run(word_frame(6'h15, 16'($urandom)), 25, 1, 0);
    run(all_frame(16'($urandom)), 25, 12, 0);
    $display("test word done");
    master_u.send(word_frame(6'($urandom), 16'($urandom)), 25, 0);
    status(30, 1'b1, 1'b1);
    start = busyTotal;
    master_u.send(all_frame(16'($urandom)), 25, 0);
    status(30, 1'b1, 1'b0);
    status(15, 1'b0, 1'b0);
    status(30, 1'b1, 1'b1);
    master_u.poll(2);
    repeat (6) @(posedge clk_sys);
    check_bit(serialOutEn_n, 1'b1);
    check_len(busyTotal - start, 64 * WORD + JOB);
    $display("test poll done");
    start = busyTotal;
    master_u.send(all_frame(16'($urandom)), 25, 0);
    for (i = 0; i < 5; i++)
      master_u.send(word_frame(6'(i), 16'($urandom)), 25, 0);
    idle();
    check_len(busyTotal - start, 68 * WORD + 5 * JOB);
    run(ctl_frame(`SUB_DISABLE), 9, 0, 0);
    run(word_frame(6'h2a, 16'($urandom)), 25, 0, 0);
    $display("test queue done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// ===== shared/eeprom_consts.svh
// timing counts, frame layout and opcode values for the serial eeprom write path
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define ADDR_BITS        6
`define DATA_BITS        16
`define WORDS            64
`define FRAME_BITS       25
`define CMD_BITS         9
`define OP_PROG          2'h0
`define OP_WRITE         2'h1
`define SUB_DISABLE      2'h0
`define SUB_WRITE_ALL    2'h1
`define SUB_ERASE_ALL    2'h2
`define SUB_ENABLE       2'h3
`define SELECT_LOW_NS    250
`define CLK_PERIOD_NS    10
`define SELECT_LOW_CYC   ((`SELECT_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYC        64
`define PROG_CYC         64
`define ERASED_WORD      16'hffff
`endif

// ===== shared/eeprom_pkg.sv
// types shared by the serial eeprom write path
package eeprom_pkg;
  typedef struct packed {
    logic        all;
    logic [5:0]  addr;
    logic [15:0] data;
  } wr_req_s;
  typedef enum logic [3:0] {
    IDLE  = 4'h1,
    ERASE = 4'h2,
    PROG  = 4'h4,
    DONE  = 4'h8
  } prog_state_e;
endpackage : eeprom_pkg
